// File: design/pwl_core.v
/*
 * Command sequencer for page write, page program and lock byte write
 * inside a serial flash, with the page array and sector lock bytes.
 * Assumes the host drives chip select, serial clock and serial input
 * in SPI mode 0 and that the serial clock is well below clk / 6.
 */
`timescale 1ns/1ns
`include "pwl_consts.vh"

// Overview of operation
// - Page write needs write latch set first
// - Page write replaces sent bytes, keeps unsent bytes
// - Data past page end wraps to start
// - Only last 256 bytes are programmed
// - Deselect off a byte boundary aborts command
// - Deselect starts cycle; busy flag; latch clears
// - Page program only clears bits, timed
// - Page write refused on protected page
// - Page program refused on hardware protection
// - Program commands rejected while cycle runs
// - Reset pin low aborts running cycle
// - Top three address bits ignored
// - Lock write needs enable and one byte
// - Lock write needs exact byte boundary
// - Lock bits volatile; latch clears at once
// - Lock write rejected while cycle runs
// - Lock byte: b1 freeze, b0 guard
// - Legacy end sectors: b7 selects subsector bits
// - Sector freeze forces subsector freeze
// - Sector guard forces subsector guards set
// - Guard clear clears unfrozen subsector guards
// - Frozen sector refuses lock changes
// - Guarded sector refuses writes
module pwl_core #(
  parameter ADDR_W      = 21,
  parameter SECT_W      = 5,
  parameter MEM_BYTES   = 2097152,
  parameter PW_CYCLES   = `PWL_PW_CYCLES,
  parameter PP_CYCLES   = `PWL_PP_CYCLES,
  parameter LEGACY      = 0
) (
  clk,
  rst,
  chip_sel_n,
  serial_clk,
  serial_in_line,
  reset_pin_n,
  hw_protect,
  write_latch_flag,
  cycle_active_flag,
  lock_rd_sector,
  sector_lock_byte
);
  input  wire              clk;
  input  wire              rst;
  input  wire              chip_sel_n;
  input  wire              serial_clk;
  input  wire              serial_in_line;
  input  wire              reset_pin_n;
  input  wire              hw_protect;
  output reg               write_latch_flag;
  output reg               cycle_active_flag;
  input  wire [SECT_W-1:0] lock_rd_sector;
  output reg  [7:0]        sector_lock_byte;

  localparam ST_IDLE = 3'b001;
  localparam ST_LOAD = 3'b010;
  localparam ST_RUN  = 3'b100;

  wire cs_n;
  wire sck;
  wire sdi;
  wire rstp_n;

  // Select, clock and data share one synchroniser depth, so their order
  // is kept; the price is about four clocks of latency on every pin, which
  // is why the serial clock must stay well below clk / 6.
  pwl_sync u_cs  (.clk(clk), .rst(rst), .pin(chip_sel_n),
                  .level(cs_n));
  pwl_sync u_sck (.clk(clk), .rst(rst), .pin(serial_clk), .level(sck));
  pwl_sync u_sdi (.clk(clk), .rst(rst), .pin(serial_in_line),
                  .level(sdi));
  pwl_sync u_rst (.clk(clk), .rst(rst), .pin(reset_pin_n),
                  .level(rstp_n));

  // The array holds no erased image of its own; bytes never written read
  // as unknown in simulation.
  reg [7:0]  mem [0:MEM_BYTES-1];
  reg [7:0]  page_buf [0:`PWL_PAGE_BYTES-1];
  // A column mark per byte lets a short write leave the others alone.
  reg        page_hit [0:`PWL_PAGE_BYTES-1];
  reg [1:0]  lock_reg [0:`PWL_SECTORS-1];
  reg [1:0]  sub_lock [0:31];

  reg        sck_q;
  reg        cs_q;
  reg [2:0]  bit_cnt;
  reg [7:0]  shift;
  reg [2:0]  byte_no;
  reg [7:0]  cmd;
  reg [23:0] addr;
  reg [7:0]  col;
  reg        got_data;
  reg [7:0]  lock_data;
  reg [2:0]  state;
  reg        is_pw;
  reg [31:0] timer;
  reg        first_wr;

  // Legacy parts keep subsector locks in the first and last sectors only.
  function is_end_sector;
    input [SECT_W-1:0] s;
    begin
      is_end_sector = (s == {SECT_W{1'b0}}) || (s == {SECT_W{1'b1}});
    end
  endfunction

  // The sector guard is applied before the freeze, so a clear guard only
  // drops subsector guards that were not frozen beforehand.
  function [1:0] merge_sub;
    input [1:0] sub;
    input [1:0] sec;
    begin
      merge_sub = {sec[1] | sub[1], sec[0] | (sub[0] & sub[1])};
    end
  endfunction

  wire sck_rise = sck & ~sck_q;
  wire cs_rise  = cs_n & ~cs_q;
  wire [7:0] byte_in = {shift[6:0], sdi};
  // Top address bits are dropped, so the page base comes from low bits.
  wire [ADDR_W-1:0] page_base = {addr[ADDR_W-1:8], 8'h00};
  wire [SECT_W-1:0] sect = addr[ADDR_W-1:ADDR_W-SECT_W];
  wire [3:0] subs = addr[ADDR_W-SECT_W-1:ADDR_W-SECT_W-4];
  wire end_sect = is_end_sector(sect);
  wire sub_guard = LEGACY && end_sect && sub_lock[{sect[0], subs}][0];
  wire guarded = lock_reg[sect][0] | sub_guard;
  // A frame counts only if it ends on a byte boundary after a data byte.
  wire framed = (bit_cnt == 3'd0) && got_data;

  integer i;

  always @(posedge clk) begin
    if (rst) begin
      // Same level as the synchroniser's reset, so no false edge follows.
      sck_q <= 1'b1;
      cs_q  <= 1'b1;
      sector_lock_byte <= 8'h00;
    end else begin
      sck_q <= sck;
      cs_q  <= cs_n;
      // Only subsector 0 of an end sector is shown; other subsectors
      // would need a wider read address than this port carries.
      sector_lock_byte <= {4'h0,
        (LEGACY && is_end_sector(lock_rd_sector)) ?
         sub_lock[{lock_rd_sector[0], 4'h0}] : 2'b00,
        lock_reg[lock_rd_sector]};
    end
  end

  // Serial framing: command byte, three address bytes, then data bytes.
  always @(posedge clk) begin
    if (rst || cs_n) begin
      bit_cnt  <= 3'd0;
      byte_no  <= 3'd0;
      shift    <= 8'h00;
      got_data <= 1'b0;
    end else if (sck_rise) begin
      shift   <= byte_in;
      bit_cnt <= bit_cnt + 3'd1;
      if (bit_cnt == 3'd7) begin
        if (byte_no != 3'd4) begin
          byte_no <= byte_no + 3'd1;
        end
        if (byte_no == 3'd4) begin
          got_data <= 1'b1;
        end
      end
    end
  end

  always @(posedge clk) begin
    // The reset pin stops the sequencer but keeps the lock bits, which
    // only a power-up (rst) clears.
    if (rst || !rstp_n) begin
      state             <= ST_IDLE;
      write_latch_flag  <= 1'b0;
      cycle_active_flag <= 1'b0;
      cmd   <= 8'h00;
      addr  <= 24'h000000;
      col   <= 8'h00;
      is_pw <= 1'b0;
      timer <= 32'd0;
      first_wr  <= 1'b0;
      lock_data <= 8'h00;
      for (i = 0; i < `PWL_PAGE_BYTES; i = i + 1) begin
        page_hit[i] <= 1'b0;
      end
      if (rst) begin
        for (i = 0; i < `PWL_SECTORS; i = i + 1) begin
          lock_reg[i] <= 2'b00;
          sub_lock[i] <= 2'b00;
        end
      end
    end else begin
      case (state)
        ST_IDLE: begin
          if (!cs_n && sck_rise && bit_cnt == 3'd7) begin
            if (byte_no == 3'd0) begin
              cmd <= byte_in;
              for (i = 0; i < `PWL_PAGE_BYTES; i = i + 1) begin
                page_hit[i] <= 1'b0;
              end
            end else if (byte_no < 3'd4) begin
              addr <= {addr[15:0], byte_in};
              if (byte_no == 3'd3) begin
                col <= byte_in;
              end
            end else begin
              // Later bytes overwrite earlier ones at the same column.
              page_buf[col] <= byte_in;
              page_hit[col] <= 1'b1;
              col <= col + 8'd1;
              lock_data <= byte_in;
            end
          end
          if (cs_rise) begin
            // A frame of exactly one byte carries a latch command.
            if (byte_no == 3'd1 && bit_cnt == 3'd0) begin
              if (cmd == `PWL_CMD_WREN) begin
                write_latch_flag <= 1'b1;
              end else if (cmd == `PWL_CMD_WRDI) begin
                write_latch_flag <= 1'b0;
              end
            end else if ((cmd == `PWL_CMD_PAGE_WR ||
                          cmd == `PWL_CMD_PAGE_PROG) &&
                         framed && write_latch_flag) begin
              // Both commands honour the protect pin and the sector guard.
              if (!hw_protect && !guarded) begin
                state <= ST_RUN;
                cycle_active_flag <= 1'b1;
                is_pw <= (cmd == `PWL_CMD_PAGE_WR);
                timer <= (cmd == `PWL_CMD_PAGE_WR) ? PW_CYCLES : PP_CYCLES;
                first_wr <= 1'b1;
              end
            end else if (cmd == `PWL_CMD_LOCK_WR && framed &&
                         write_latch_flag) begin
              // The latch drops on every framed lock write, refused or not,
              // so a stale enable is never carried into the next command.
              write_latch_flag <= 1'b0;
              if (!lock_reg[sect][1]) begin
                if (LEGACY && end_sect &&
                    lock_data[`PWL_LOCK_SUB_BIT]) begin
                  if (!sub_lock[{sect[0], subs}][1]) begin
                    sub_lock[{sect[0], subs}] <= lock_data[3:2];
                  end
                end else begin
                  lock_reg[sect] <= lock_data[1:0];
                  if (LEGACY && end_sect) begin
                    for (i = 0; i < 16; i = i + 1) begin
                      sub_lock[{sect[0], i[3:0]}] <= merge_sub(
                        sub_lock[{sect[0], i[3:0]}],
                        lock_data[1:0]);
                    end
                  end
                end
              end
            end
          end
        end
        ST_RUN: begin
          // Frames during the cycle are ignored, so rejection is silent.
          // The page is updated in the first run cycle and the rest only
          // times the cycle, so an abort by the reset pin may leave new
          // data in place, a corruption that the device is allowed.
          if (first_wr) begin
            first_wr <= 1'b0;
            for (i = 0; i < `PWL_PAGE_BYTES; i = i + 1) begin
              if (page_hit[i]) begin
                mem[page_base + i[ADDR_W-1:0]] <=
                  is_pw ? page_buf[i] :
                  (mem[page_base + i[ADDR_W-1:0]] & page_buf[i]);
              end
            end
            write_latch_flag <= 1'b0;
          end
          // Counting down from the full figure gives that many busy clocks.
          if (timer <= 32'd1) begin
            state <= ST_IDLE;
            cycle_active_flag <= 1'b0;
          end else begin
            timer <= timer - 32'd1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// File: design/pwl_consts.vh
/*
 * Constants for the page write, page program and lock byte command block.
 * Assumes a 50 MHz system clock; times are given in nanoseconds.
 */
`ifndef PWL_CONSTS_VH
`define PWL_CONSTS_VH

`define PWL_CMD_WREN      8'h06
`define PWL_CMD_WRDI      8'h04
`define PWL_CMD_PAGE_WR   8'h0A
`define PWL_CMD_PAGE_PROG 8'h02
`define PWL_CMD_LOCK_WR   8'hE5

`define PWL_CLK_NS        20
`define PWL_PW_TIME_NS    11000000
`define PWL_PP_TIME_NS    800000
`define PWL_PW_CYCLES     (`PWL_PW_TIME_NS / `PWL_CLK_NS)
`define PWL_PP_CYCLES     (`PWL_PP_TIME_NS / `PWL_CLK_NS)

`define PWL_LOCK_GUARD_BIT   0
`define PWL_LOCK_FREEZE_BIT  1
`define PWL_LOCK_SGUARD_BIT  2
`define PWL_LOCK_SFREEZE_BIT 3
`define PWL_LOCK_SUB_BIT  7

`define PWL_PAGE_BYTES    256
`define PWL_SECTORS       32

`endif

// File: design/pwl_sync.v
/*
 * Three-stage synchroniser for pins from outside the clock domain.
 * A change counts once the second and third stages agree.
 */
`timescale 1ns/1ns
module pwl_sync (
  clk,
  rst,
  pin,
  level
);
  input  wire clk;
  input  wire rst;
  input  wire pin;
  output reg  level;

  reg s1;
  reg s2;
  reg s3;

  always @(posedge clk) begin
    if (rst) begin
      s1    <= 1'b1;
      s2    <= 1'b1;
      s3    <= 1'b1;
      level <= 1'b1;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end
endmodule

// File: test/pwl_core_assertions.sv
/* Checker for the pwl_core flags and lock byte.
   Sees only core ports; bound to every pwl_core after the module. */
`timescale 1ns/1ns
module pwl_core_assertions #(
  parameter PW_CYCLES = 900,
  parameter PP_CYCLES = 600
) (
  input wire       clk,
  input wire       rst,
  input wire       chip_sel_n,
  input wire       reset_pin_n,
  input wire       write_latch_flag,
  input wire       cycle_active_flag,
  input wire [4:0] lock_rd_sector,
  input wire [7:0] sector_lock_byte
);
  reg [31:0] len;
  reg        abrt;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // A run cut by the reset pin has no fixed length, so it is excluded.
  always @(posedge clk) begin
    len  <= cycle_active_flag ? len + 1 : 0;
    abrt <= !reset_pin_n | (abrt & cycle_active_flag);
  end
  a_flags_after_reset: assert property ($fell(rst) |->
    !write_latch_flag && !cycle_active_flag) else $error("flags after rst");
  a_latch_then_busy: assert property ($rose(cycle_active_flag) |->
    $past(write_latch_flag) ##[0:2] !write_latch_flag) else $error("latch");
  a_busy_on_deselect: assert property ($rose(cycle_active_flag) |->
    chip_sel_n && $past(chip_sel_n) && reset_pin_n) else $error("busy start");
  a_busy_run_length: assert property (
    $fell(cycle_active_flag) && !abrt |->
    len == PP_CYCLES || len == PW_CYCLES) else $error("busy length");
  a_pin_aborts: assert property ($fell(reset_pin_n) |-> ##[1:8]
    !cycle_active_flag && !write_latch_flag) else $error("no abort");
  a_lock_upper_zero: assert property (sector_lock_byte[7:2] == 6'h00)
    else $error("lock reserved bits");
  a_lock_no_time: assert property ($changed(sector_lock_byte)
    && $stable(lock_rd_sector) && $past(lock_rd_sector, 2) == lock_rd_sector
    |-> !cycle_active_flag ##[0:3] !write_latch_flag) else $error("lock wr");
  a_latch_rise_idle: assert property ($rose(write_latch_flag) |->
    chip_sel_n && !cycle_active_flag) else $error("latch rise");
endmodule

bind pwl_core pwl_core_assertions #(
  .PW_CYCLES(PW_CYCLES),
  .PP_CYCLES(PP_CYCLES)
) u_chk (
  .clk              (clk),
  .rst              (rst),
  .chip_sel_n       (chip_sel_n),
  .reset_pin_n      (reset_pin_n),
  .write_latch_flag (write_latch_flag),
  .cycle_active_flag(cycle_active_flag),
  .lock_rd_sector   (lock_rd_sector),
  .sector_lock_byte (sector_lock_byte)
);

// File: test/pwl_spi_host.sv
/* SPI host model, mode 0, serial clock period 160 ns.
   Callers may end a frame part way through a byte; the clock idles low. */
`timescale 1ns/1ns
module pwl_spi_host (
  output reg chip_sel_n,
  output reg serial_clk,
  output reg serial_in_line
);
  initial begin
    chip_sel_n = 1'b1;
    serial_clk = 1'b0;
    serial_in_line = 1'b0;
  end
  task shift(input [7:0] b, input integer nb);
    integer i;
    for (i = 7; i > 7 - nb; i = i - 1) begin
      serial_in_line = b[i];
      #80 serial_clk = 1'b1;
      #80 serial_clk = 1'b0;
    end
  endtask
  task sel;
    chip_sel_n = 1'b0;
    #160;
  endtask
  // The released line flips so a stale bit is never read as valid.
  task desel;
    #80 chip_sel_n = 1'b1;
    serial_in_line = ~serial_in_line;
    #800;
  endtask
endmodule

// File: test/pwl_core_tb_top.sv
/* Bench for pwl_core: command frames through the host model.
   Assumes short cycle counts set by parameter. */
`timescale 1ns/1ns
module pwl_core_tb_top;
  localparam PW = 900;
  localparam PP = 600;
  reg        clk = 1'b0;
  reg        rst = 1'b1;
  reg        reset_pin_n = 1'b1;
  reg        hw_protect = 1'b0;
  reg  [4:0] sect = 5'h00;
  wire       cs_n, sck, sdi, wl, busy;
  wire [7:0] lock;
  integer    n_mismatch = 0;
  integer    tests_run = 0;
  integer    run_len = 0;
  integer    last_len = 0;
  integer    j;
  always #10 clk = ~clk;
  pwl_spi_host host (.chip_sel_n(cs_n), .serial_clk(sck),
                     .serial_in_line(sdi));
  pwl_core #(.PW_CYCLES(PW), .PP_CYCLES(PP)) DUT (
    .clk(clk), .rst(rst), .chip_sel_n(cs_n), .serial_clk(sck),
    .serial_in_line(sdi), .reset_pin_n(reset_pin_n), .hw_protect(hw_protect),
    .write_latch_flag(wl), .cycle_active_flag(busy),
    .lock_rd_sector(sect), .sector_lock_byte(lock));
  always @(posedge clk) begin
    if (busy === 1'b1) run_len <= run_len + 1;
    else begin
      if (run_len != 0) last_len <= run_len;
      run_len <= 0;
    end
  end
  task check(input [31:0] seen, input [31:0] exp, input string what);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("MISMATCH %s exp %0h seen %0h", what, exp, seen);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task frame(input [7:0] c, input [23:0] a, input integer nd,
             input [7:0] d, input integer tail);
    integer i;
    host.sel;
    host.shift(c, 8);
    for (i = 2; i >= 0 && nd >= 0; i = i - 1) host.shift(a[i*8 +: 8], 8);
    for (i = 0; i < nd; i = i + 1) host.shift(d, 8);
    if (tail > 0) host.shift(d, tail);
    host.desel;
  endtask
  task wren;
    frame(8'h06, 24'h000000, -1, 8'h00, 0);
  endtask
  task wait_idle;
    integer k;
    for (k = 0; k < 2000 && busy !== 1'b0; k = k + 1) tick(1);
    // One more clock lets the run-length monitor latch the finished run.
    tick(1);
  endtask
  initial begin
    tick(16);
    rst = 1'b0;
    tick(8);
    check(wl, 0, "latch");
    check(lock, 0, "lock");
    frame(8'h02, 24'h000010, 1, 8'h5A, 0);
    check(busy, 0, "no latch");
    wren;
    check(wl, 1, "latch set");
    frame(8'h02, 24'h000010, 2, 8'hA5, 3);
    check(busy, 0, "framing");
    $display("test refuse done");
    wren;
    frame(8'h02, 24'hE000FE, 257, 8'h00, 0);
    check(busy, 1, "pp busy");
    frame(8'hE5, 24'h030000, 1, 8'h01, 0);
    wait_idle;
    check(last_len, PP, "pp len");
    check(wl, 0, "latch clr");
    check(DUT.mem[21'h000000], 8'h00, "pp wrap");
    check(DUT.mem[21'h0000FE], 8'h00, "pp start");
    sect = 5'h03;
    tick(3);
    check(lock, 0, "busy lock");
    hw_protect = 1'b1;
    for (j = 0; j < 2; j = j + 1) begin
      wren;
      frame(j ? 8'h02 : 8'h0A, 24'h000100, 1, 8'h00, 0);
      check(busy, 0, "protect");
    end
    hw_protect = 1'b0;
    $display("test program done");
    wren;
    frame(8'hE5, 24'h03ABCD, 1, 8'h01, 0);
    check(lock, 1, "guard");
    check(wl, 0, "lock latch");
    wren;
    frame(8'h0A, 24'h030000, 1, 8'h00, 0);
    check(busy, 0, "guarded");
    wren;
    frame(8'hE5, 24'h030000, 1, 8'h00, 7);
    check(lock, 1, "lock frame");
    wren;
    frame(8'hE5, 24'h03FFFF, 1, 8'h02, 0);
    check(lock, 2, "freeze");
    wren;
    frame(8'hE5, 24'h030000, 1, 8'h00, 0);
    check(lock, 2, "frozen");
    sect = 5'h04;
    tick(3);
    check(lock, 0, "sector");
    $display("test lock done");
    wren;
    frame(8'h0A, 24'h050000, 3, 8'h77, 0);
    check(busy, 1, "pw busy");
    wait_idle;
    check(last_len, PW, "pw len");
    check(DUT.mem[21'h050002], 8'h77, "pw data");
    wren;
    frame(8'h02, 24'h050001, 1, 8'h5A, 0);
    wait_idle;
    check(DUT.mem[21'h050001], 8'h52, "pp clears");
    check(DUT.mem[21'h050000], 8'h77, "pp others");
    wren;
    frame(8'h02, 24'h050000, 1, 8'h00, 0);
    reset_pin_n = 1'b0;
    tick(20);
    check(busy, 0, "abort");
    check(wl, 0, "abort latch");
    reset_pin_n = 1'b1;
    sect = 5'h03;
    tick(50);
    check(lock, 2, "kept");
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(3);
    check(lock, 0, "rst lock");
    $display("test reset done");
    tally_and_finish;
  end
  initial begin
    #1000000;
    n_mismatch = n_mismatch + 1;
    tally_and_finish;
  end
endmodule
